/* File: fnsyn_regs.svh */
// Purpose: constants of the synthesizer loop configuration block
// Assumes: serial frame of 24 bits, address in the top two bits
// Notes:   field positions index the received frame
`ifndef FNSYN_REGS_SVH
`define FNSYN_REGS_SVH

`define FNSYN_FRAME_W        24
`define FNSYN_ADDR_HI        23
`define FNSYN_ADDR_LO        22
`define FNSYN_ADDR_DEVICE    2'h0
`define FNSYN_ADDR_MAIN      2'h1
`define FNSYN_ADDR_DIVIDE    2'h2
`define FNSYN_ADDR_GAIN      2'h3
// device word
`define FNSYN_MODE_BIT       21
`define FNSYN_REFCNT_HI      11
`define FNSYN_REFCNT_LO      0
// main word
`define FNSYN_PRESC_HI       21
`define FNSYN_PRESC_LO       20
`define FNSYN_FRACMOD_HI     19
`define FNSYN_FRACMOD_LO     15
`define FNSYN_FRACNUM_HI     14
`define FNSYN_FRACNUM_LO     11
`define FNSYN_MPOST_HI       10
`define FNSYN_MPOST_LO       9
`define FNSYN_MPOL_BIT       8
`define FNSYN_G_HI           7
`define FNSYN_G_LO           4
// divide word
`define FNSYN_ND_HI          21
`define FNSYN_ND_LO          12
`define FNSYN_AUXDIV_HI      11
`define FNSYN_AUXDIV_LO      0
// gain word
`define FNSYN_MGAIN_HI       21
`define FNSYN_MGAIN_LO       14
`define FNSYN_PGAIN_HI       13
`define FNSYN_PGAIN_LO       10
`define FNSYN_IGAIN_HI       9
`define FNSYN_IGAIN_LO       6
`define FNSYN_APOST_HI       5
`define FNSYN_APOST_LO       4
`define FNSYN_APOL_BIT       3
// reset values and codes
`define FNSYN_PRESC_TWO_MOD    2'h1
`define FNSYN_PRESC_THREE_MOD  2'h2
`define FNSYN_FRACMOD_LEG_FIVE 5'h00
`define FNSYN_MOD_FIVE       5'h05
`define FNSYN_MOD_EIGHT      5'h08
`define FNSYN_G_SHORT        4'hf
// speed-up span is 16 comparison periods per step of its code
`define FNSYN_SPEEDUP_SHIFT  4
`define FNSYN_REFCNT_RESET   12'h001

`endif

/* File: fnsyn_pkg.sv */
// Purpose: types of the synthesizer loop configuration block
// Assumes: nothing
// Notes:   field widths follow the serial frame layout
package fnsyn_pkg;

   typedef enum logic [1:0]
   {
      FNSYN_PRESC_64_65    = 2'h0,
      FNSYN_PRESC_64_65_72 = 2'h1,
      FNSYN_PRESC_32_33    = 2'h3
   } fnsyn_presc_e;

   typedef enum logic [1:0]
   {
      FNSYN_SU_IDLE = 2'h0,
      FNSYN_SU_RUN  = 2'h1
   } fnsyn_su_e;

   typedef struct packed
   {
      logic        enhanced;
      logic [11:0] refCount;
   } fnsyn_dev_s;

   typedef struct packed
   {
      logic [1:0] prescCfg;
      logic [4:0] fracMod;
      logic [3:0] fracNum;
      logic [1:0] mainPost;
      logic       mainPol;
      logic [3:0] speedCode;
   } fnsyn_main_s;

   typedef struct packed
   {
      logic [7:0] mainGain;
      logic [3:0] propGain;
      logic [3:0] integGain;
      logic [1:0] auxPost;
      logic       auxPol;
   } fnsyn_gain_s;

endpackage

/* File: fnsyn_postscale.sv */
// Purpose: reference postscaler, divides a tick stream by 1, 2, 4 or 8
// Assumes: tickIn is a one-cycle enable
// Notes:   used for both the main and the auxiliary phase detector
`timescale 1ns/100ps
module fnsyn_postscale
   import fnsyn_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       tickIn,
   input  wire logic [1:0] sel,
   output logic            tickOut
);

   logic [2:0] cnt_r;
   logic [2:0] lim;

   assign lim = 3'((4'h1 << sel) - 4'h1);

   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_r <= 3'h0;
      else if (tickIn)
         cnt_r <= (cnt_r >= lim) ? 3'h0 : cnt_r + 3'h1;
   end

   // wrap point of the count marks one output tick
   assign tickOut = tickIn && (cnt_r >= lim);

   property p_div_one;
      @(posedge clk) disable iff (srst) (sel == 2'h0 && tickIn) |-> tickOut;
   endproperty
   a_div_one: assert property (p_div_one) else $error("postscale by one dropped a tick");

   property p_div_eight;
      @(posedge clk) disable iff (srst) (sel == 2'h3 && tickOut) |-> cnt_r == 3'h7;
   endproperty
   a_div_eight: assert property (p_div_eight) else $error("postscale by eight fired early");

endmodule

/* File: fnsyn_frac_accum.sv */
// Purpose: fractional accumulator of the main loop
// Assumes: numerator below modulus is the host's duty
// Notes:   an oversized numerator still wraps but gives a carry every step
`timescale 1ns/100ps
module fnsyn_frac_accum
   import fnsyn_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       step,
   input  wire logic [3:0] numer,
   input  wire logic [4:0] modulus,
   output logic            carry,
   output logic [4:0]      accum
);

   logic [5:0] sum;
   logic       over;

   assign sum  = {1'b0, accum} + {2'h0, numer};
   assign over = sum >= {1'b0, modulus};

   always_ff @(posedge clk)
   begin
      if (srst)
         accum <= 5'h00;
      else if (step)
         accum <= over ? 5'(sum - {1'b0, modulus}) : sum[4:0];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         carry <= 1'b0;
      else if (step)
         carry <= over;
   end

   property p_accum_bound;
      @(posedge clk) disable iff (srst) $past(step) && numer < modulus && $past(numer) < $past(modulus)
         && $stable(modulus) && $past(accum) < $past(modulus) |-> accum < modulus;
   endproperty
   a_accum_bound: assert property (p_accum_bound) else $error("accumulator left its modulus");

endmodule

/* File: fnsyn_loop_config.sv */
// Purpose: serial-programmed control of a dual-loop fractional-N synthesizer
// Assumes: clk is the reference input; serial pins synchronous to clk
// Notes:   frame of 24 bits shifted in on serial clock rises, taken on strobe rise
// Notes on behaviour
// - In legacy mode prescaler_config 1 picks the 64/65 prescaler and 2 the 64/65/72 prescaler.
// - In enhanced mode prescaler_config is ignored and the prescaler is always 32/33.
// - Legacy fraction_modulus 0 gives modulo five and 1 modulo eight; enhanced 1 to 16 gives that modulo.
// - fraction_numerator is what the fractional accumulator adds each step.
// - main_ref_postscale codes 0 to 3 divide the main comparison reference by 1, 2, 4 and 8.
// - In enhanced mode main_pump_polarity 0 is positive and 1 negative.
// - Enhanced speed-up codes 0 to 14 last (code+1) times reference_count times postscale times 16 periods.
// - Speed-up code 15 lasts under half a comparison period.
// - aux_ref_postscale codes 0 to 3 divide the auxiliary comparison reference by 1, 2, 4 and 8.
// - In enhanced mode aux_pump_polarity 0 is positive and 1 negative.
// - main_pump_gain sets the main pump gain in normal operation.
// - speedup_proportional_gain sets the proportional gain while speed-up runs.
// - speedup_integral_gain sets the integral gain while speed-up runs.
// - device_mode_select 0 is legacy emulation and 1 enhanced performance mode.
// - All fields arrive over serial clock, data and strobe, all driven by the host.
`timescale 1ns/100ps
`include "fnsyn_regs.svh"
module fnsyn_loop_config
   import fnsyn_pkg::*;
#(
   parameter int FRAME_W = `FNSYN_FRAME_W
)
(
   input  wire logic    clk,
   input  wire logic    srst,
   input  wire logic    serialClock,
   input  wire logic    serialData,
   input  wire logic    serialStrobe,
   output logic         enhancedMode,
   output fnsyn_presc_e prescMode,
   output logic [4:0]   fracModulus,
   output logic [9:0]   mainDivide,
   output logic [10:0]  mainRatio,
   output logic [11:0]  auxDivide,
   output logic [4:0]   fracAccum,
   output logic         mainPdTick,
   output logic         auxPdTick,
   output logic         mainPumpNegative,
   output logic         auxPumpNegative,
   output logic [7:0]   mainPumpGain,
   output logic [3:0]   propPumpGain,
   output logic [3:0]   integPumpGain,
   output logic         speedupActive
);

   fnsyn_dev_s          dev_r;
   fnsyn_main_s         main_r;
   fnsyn_gain_s         gain_r;
   logic [FRAME_W-1:0]  shift_r;
   logic                clkPrev_r;
   logic                strbPrev_r;
   logic                loadMain_r;
   logic [11:0]         refCnt_r;
   logic                refTick;
   logic                fracCarry;
   logic [1:0]          addr;
   logic                take;
   fnsyn_su_e           suState_r;
   fnsyn_su_e           suState_nxt;
   logic [23:0]         suCnt_r;
   logic [23:0]         suLen;
   logic [15:0]         pdPeriod;
   logic                suStart;
   logic                suEnhActive;
   logic [4:0]          modulusLegacy;

   ////////////////////////////////////////////////////////////////////////////
   // serial reception

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         clkPrev_r  <= 1'b0;
         strbPrev_r <= 1'b0;
      end
      else
      begin
         clkPrev_r  <= serialClock;
         strbPrev_r <= serialStrobe;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         shift_r <= '0;
      else if (serialClock && !clkPrev_r)
         shift_r <= {shift_r[FRAME_W-2:0], serialData};
   end

   assign take = serialStrobe && !strbPrev_r;
   assign addr = shift_r[`FNSYN_ADDR_HI:`FNSYN_ADDR_LO];

   ////////////////////////////////////////////////////////////////////////////
   // configuration words

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         dev_r.enhanced <= 1'b0;
         dev_r.refCount <= `FNSYN_REFCNT_RESET;
      end
      else if (take && addr == `FNSYN_ADDR_DEVICE)
      begin
         dev_r.enhanced <= shift_r[`FNSYN_MODE_BIT];
         dev_r.refCount <= shift_r[`FNSYN_REFCNT_HI:`FNSYN_REFCNT_LO];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         main_r.prescCfg  <= `FNSYN_PRESC_TWO_MOD;
         main_r.fracMod   <= `FNSYN_FRACMOD_LEG_FIVE;
         main_r.fracNum   <= 4'h0;
         main_r.mainPost  <= 2'h0;
         main_r.mainPol   <= 1'b0;
         main_r.speedCode <= `FNSYN_G_SHORT;
      end
      else if (take && addr == `FNSYN_ADDR_MAIN)
      begin
         main_r.prescCfg  <= shift_r[`FNSYN_PRESC_HI:`FNSYN_PRESC_LO];
         main_r.fracMod   <= shift_r[`FNSYN_FRACMOD_HI:`FNSYN_FRACMOD_LO];
         main_r.fracNum   <= shift_r[`FNSYN_FRACNUM_HI:`FNSYN_FRACNUM_LO];
         main_r.mainPost  <= shift_r[`FNSYN_MPOST_HI:`FNSYN_MPOST_LO];
         main_r.mainPol   <= shift_r[`FNSYN_MPOL_BIT];
         main_r.speedCode <= shift_r[`FNSYN_G_HI:`FNSYN_G_LO];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mainDivide <= 10'h000;
         auxDivide  <= 12'h000;
      end
      else if (take && addr == `FNSYN_ADDR_DIVIDE)
      begin
         mainDivide <= shift_r[`FNSYN_ND_HI:`FNSYN_ND_LO];
         auxDivide  <= shift_r[`FNSYN_AUXDIV_HI:`FNSYN_AUXDIV_LO];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         gain_r <= '0;
      else if (take && addr == `FNSYN_ADDR_GAIN)
      begin
         gain_r.mainGain  <= shift_r[`FNSYN_MGAIN_HI:`FNSYN_MGAIN_LO];
         gain_r.propGain  <= shift_r[`FNSYN_PGAIN_HI:`FNSYN_PGAIN_LO];
         gain_r.integGain <= shift_r[`FNSYN_IGAIN_HI:`FNSYN_IGAIN_LO];
         gain_r.auxPost   <= shift_r[`FNSYN_APOST_HI:`FNSYN_APOST_LO];
         gain_r.auxPol    <= shift_r[`FNSYN_APOL_BIT];
      end
   end

   // a new channel word starts speed-up one cycle after it is taken
   always_ff @(posedge clk)
   begin
      if (srst)
         loadMain_r <= 1'b0;
      else
         loadMain_r <= take && addr == `FNSYN_ADDR_DIVIDE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode decode

   assign enhancedMode = dev_r.enhanced;

   always_comb
   begin
      if (dev_r.enhanced)
         prescMode = FNSYN_PRESC_32_33;
      else if (main_r.prescCfg == `FNSYN_PRESC_THREE_MOD)
         prescMode = FNSYN_PRESC_64_65_72;
      else
         prescMode = FNSYN_PRESC_64_65;
   end

   // legacy codes above 1 are undefined and read as modulo eight
   assign modulusLegacy = (main_r.fracMod == `FNSYN_FRACMOD_LEG_FIVE) ? `FNSYN_MOD_FIVE : `FNSYN_MOD_EIGHT;
   // enhanced code 0 is outside 1..16 and is held at modulo one
   assign fracModulus = dev_r.enhanced ? ((main_r.fracMod == 5'h00) ? 5'h01 : main_r.fracMod)
                                       : modulusLegacy;

   assign mainPumpNegative = dev_r.enhanced && main_r.mainPol;
   assign auxPumpNegative  = dev_r.enhanced && gain_r.auxPol;

   ////////////////////////////////////////////////////////////////////////////
   // reference counter, postscalers, accumulator

   always_ff @(posedge clk)
   begin
      if (srst)
         refCnt_r <= 12'h000;
      else
         refCnt_r <= refTick ? 12'h000 : refCnt_r + 12'h001;
   end

   // a count of zero behaves as one
   assign refTick = (refCnt_r + 12'h001 >= dev_r.refCount);

   fnsyn_postscale u_mainPost
   (
      .clk     (clk),
      .srst    (srst),
      .tickIn  (refTick),
      .sel     (main_r.mainPost),
      .tickOut (mainPdTick)
   );

   fnsyn_postscale u_auxPost
   (
      .clk     (clk),
      .srst    (srst),
      .tickIn  (refTick),
      .sel     (gain_r.auxPost),
      .tickOut (auxPdTick)
   );

   fnsyn_frac_accum u_accum
   (
      .clk     (clk),
      .srst    (srst),
      .step    (mainPdTick),
      .numer   (main_r.fracNum),
      .modulus (fracModulus),
      .carry   (fracCarry),
      .accum   (fracAccum)
   );

   assign mainRatio = {1'b0, mainDivide} + {10'h000, fracCarry};

   ////////////////////////////////////////////////////////////////////////////
   // speed-up timer

   assign pdPeriod = {4'h0, (dev_r.refCount == 12'h000) ? 12'h001 : dev_r.refCount} << main_r.mainPost;

   always_comb
   begin
      if (main_r.speedCode == `FNSYN_G_SHORT)
         suLen = {9'h000, pdPeriod[15:1]} - {23'h0, |pdPeriod[15:1]};
      else
         suLen = 24'(({20'h0, main_r.speedCode} + 24'h1) * {8'h0, pdPeriod}) << `FNSYN_SPEEDUP_SHIFT;
   end

   assign suStart = loadMain_r && dev_r.enhanced && suLen != 24'h0;

   always_comb
   begin
      case (suState_r)
         FNSYN_SU_IDLE: suState_nxt = suStart ? FNSYN_SU_RUN : FNSYN_SU_IDLE;
         FNSYN_SU_RUN:  suState_nxt = (suCnt_r <= 24'h1 && !suStart) ? FNSYN_SU_IDLE : FNSYN_SU_RUN;
         default:       suState_nxt = FNSYN_SU_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         suState_r <= FNSYN_SU_IDLE;
      else
         suState_r <= suState_nxt;
   end

   // a fresh channel word restarts the full duration
   always_ff @(posedge clk)
   begin
      if (srst)
         suCnt_r <= 24'h0;
      else if (suStart)
         suCnt_r <= suLen;
      else if (suCnt_r != 24'h0)
         suCnt_r <= suCnt_r - 24'h1;
   end

   assign suEnhActive = (suState_r == FNSYN_SU_RUN);
   // legacy mode leaves the speed-up length to the host strobe width
   assign speedupActive = dev_r.enhanced ? suEnhActive : serialStrobe;

   assign mainPumpGain  = gain_r.mainGain;
   assign propPumpGain  = speedupActive ? gain_r.propGain : 4'h0;
   assign integPumpGain = speedupActive ? gain_r.integGain : 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_presc_enh;
      @(posedge clk) disable iff (srst) enhancedMode |-> prescMode == FNSYN_PRESC_32_33;
   endproperty
   a_presc_enh: assert property (p_presc_enh) else $error("enhanced prescaler not 32/33");

   property p_presc_leg;
      @(posedge clk) disable iff (srst) !enhancedMode && main_r.prescCfg == 2'h2 |-> prescMode == FNSYN_PRESC_64_65_72;
   endproperty
   a_presc_leg: assert property (p_presc_leg) else $error("legacy three-modulus not selected");

   property p_mod_leg;
      @(posedge clk) disable iff (srst) !enhancedMode |-> fracModulus == ((main_r.fracMod == 5'h0) ? 5'h5 : 5'h8);
   endproperty
   a_mod_leg: assert property (p_mod_leg) else $error("legacy modulus decode wrong");

   property p_pol_leg;
      @(posedge clk) disable iff (srst) !enhancedMode |-> !mainPumpNegative && !auxPumpNegative;
   endproperty
   a_pol_leg: assert property (p_pol_leg) else $error("legacy polarity not positive");

   property p_ratio;
      @(posedge clk) disable iff (srst) fracCarry |-> mainRatio == mainDivide + 11'h1;
   endproperty
   a_ratio: assert property (p_ratio) else $error("carry did not raise ratio");

   property p_su_start;
      @(posedge clk) disable iff (srst) suStart |=> speedupActive && suCnt_r == $past(suLen);
   endproperty
   a_su_start: assert property (p_su_start) else $error("speed-up did not start");

   property p_su_end;
      @(posedge clk) disable iff (srst) enhancedMode && suEnhActive && suCnt_r == 24'h1 && !suStart
         |=> !speedupActive;
   endproperty
   a_su_end: assert property (p_su_end) else $error("speed-up overran its length");

   property p_gain_su;
      @(posedge clk) disable iff (srst) speedupActive |-> propPumpGain == gain_r.propGain
         && integPumpGain == gain_r.integGain;
   endproperty
   a_gain_su: assert property (p_gain_su) else $error("speed-up gains not applied");

   property p_mode;
      @(posedge clk) disable iff (srst) take && addr == 2'h0 |=> enhancedMode == $past(shift_r[21]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode bit not taken");

endmodule

/* File: fnsyn_host_model.sv */
// Purpose: host side of the three-wire programming link
// Assumes: each serial clock phase lasts one clk cycle
// Notes:   clock idles low; data shows the inverse of the last bit between frames
`timescale 1ns/100ps
module fnsyn_host_model
(
   input  wire logic clk,
   output logic      serialClock,
   output logic      serialData,
   output logic      serialStrobe
);

   initial
   begin
      serialClock  = 1'b0;
      serialData   = 1'b1;
      serialStrobe = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // msb first; strobe rises the cycle after the last rise has been sampled
   task automatic send(input logic [23:0] frame, input int strobeCycles);
      for (int i = 23; i >= 0; i--)
      begin
         @(posedge clk) #1;
         serialClock = 1'b0;
         serialData  = frame[i];
         @(posedge clk) #1;
         serialClock = 1'b1;
      end
      @(posedge clk) #1;
      serialClock  = 1'b0;
      serialData   = ~frame[0];
      serialStrobe = 1'b1;
      // strobe width sets legacy speed-up; kept far below 600 us so runs stay short
      repeat (strobeCycles) @(posedge clk);
      #1;
      serialStrobe = 1'b0;
   endtask

endmodule

/* File: tb.sv */
// Purpose: self-checking bench of the loop configuration block
// Assumes: one clk cycle per serial clock phase, inputs moved 1 ns after a rise
// Notes:   small reference counts keep tick periods and speed-up spans short
`timescale 1ns/100ps
`include "fnsyn_regs.svh"
module tb
   import fnsyn_pkg::*;
;
   logic         clk;
   logic         srst;
   wire logic    serialClock;
   wire logic    serialData;
   wire logic    serialStrobe;
   logic         enhancedMode;
   fnsyn_presc_e prescMode;
   logic [4:0]   fracModulus;
   logic [9:0]   mainDivide;
   logic [10:0]  mainRatio;
   logic [11:0]  auxDivide;
   logic [4:0]   fracAccum;
   logic         mainPdTick;
   logic         auxPdTick;
   logic         mainPumpNegative;
   logic         auxPumpNegative;
   logic [7:0]   mainPumpGain;
   logic [3:0]   propPumpGain;
   logic [3:0]   integPumpGain;
   logic         speedupActive;
   int           fails = 0;
   int           samplesChecked = 0;
   logic [31:0]  seed = 32'hb2c04686;

   fnsyn_host_model i_host (.clk(clk), .serialClock(serialClock), .serialData(serialData),
                            .serialStrobe(serialStrobe));

   fnsyn_loop_config #(.FRAME_W(24)) i_dut (.clk(clk), .srst(srst), .serialClock(serialClock),
      .serialData(serialData), .serialStrobe(serialStrobe), .enhancedMode(enhancedMode),
      .prescMode(prescMode), .fracModulus(fracModulus), .mainDivide(mainDivide), .mainRatio(mainRatio),
      .auxDivide(auxDivide), .fracAccum(fracAccum), .mainPdTick(mainPdTick), .auxPdTick(auxPdTick),
      .mainPumpNegative(mainPumpNegative), .auxPumpNegative(auxPumpNegative), .mainPumpGain(mainPumpGain),
      .propPumpGain(propPumpGain), .integPumpGain(integPumpGain), .speedupActive(speedupActive));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [23:0] devWord(input logic m, input logic [11:0] rc);
      return {`FNSYN_ADDR_DEVICE, m, 9'h000, rc};
   endfunction

   function automatic logic [23:0] mainWord(input logic [1:0] ps, input logic [4:0] fm, input logic [3:0] num,
                                            input logic [1:0] post, input logic pol, input logic [3:0] g);
      return {`FNSYN_ADDR_MAIN, ps, fm, num, post, pol, g, 4'h0};
   endfunction

   function automatic logic [23:0] gainWord(input logic [7:0] mg, input logic [3:0] pgn, input logic [3:0] ign,
                                            input logic [1:0] post, input logic pol);
      return {`FNSYN_ADDR_GAIN, mg, pgn, ign, post, pol, 3'h0};
   endfunction

   function automatic logic [23:0] divWord(input logic [9:0] nd, input logic [11:0] ad);
      return {`FNSYN_ADDR_DIVIDE, nd, ad};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic doReset();
      srst = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      srst = 1'b0;
   endtask

   // a frame plus enough edges for the fields to land
   task automatic put(input logic [23:0] f);
      i_host.send(f, 1);
      repeat (3) @(posedge clk);
      #1;
   endtask

   // length of the next speed-up span, with the gains seen in its first cycle
   task automatic spanOf(output int n, output logic [3:0] pg, output logic [3:0] ig);
      int w;
      w = 0;
      n = 0;
      while (speedupActive !== 1'b1 && w < 300)
      begin
         @(negedge clk);
         w++;
      end
      pg = propPumpGain;
      ig = integPumpGain;
      while (speedupActive === 1'b1 && n < 5000)
      begin
         n++;
         @(negedge clk);
      end
   endtask

   task automatic periodOf(input logic aux, output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while ((aux ? auxPdTick : mainPdTick) !== 1'b1 && n < 300);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int         m;
      int         fm;
      int         n;
      int         e;
      int         acc;
      int         crr;
      int         gl[4];
      logic [3:0] pg;
      logic [3:0] ig;
      logic [3:0] propG;
      logic [3:0] integG;
      logic [3:0] numer;
      logic [7:0] mGain;
      logic [9:0] nd;
      gl = '{0, 2, 14, 15};
      doReset();
      check(enhancedMode, 0);
      check(prescMode, FNSYN_PRESC_64_65);
      check(fracModulus, 5);
      check(speedupActive, 0);
      for (m = 0; m < 2; m++)
      begin
         put(devWord(m[0], 12'h001));
         check(enhancedMode, m);
         for (fm = 0; fm < 17; fm++)
         begin
            put(mainWord(2'(1 + fm % 2), fm[4:0], 4'h0, 2'h0, 1'b0, 4'hf));
            e = m ? (fm ? fm : 1) : (fm ? 8 : 5);
            check(fracModulus, e);
            e = m ? 3 : (fm % 2);
            check(prescMode, e);
         end
         $display("mode %0d prescaler and modulus done", m);
      end
      for (m = 0; m < 2; m++)
      begin
         put(devWord(m[0], 12'h001));
         for (n = 0; n < 4; n++)
         begin
            mGain = 8'(rnd());
            put(mainWord(2'h1, 5'h08, 4'h0, 2'h0, n[0], 4'hf));
            put(gainWord(mGain, 4'h0, 4'h0, 2'h0, n[1]));
            check(mainPumpNegative, m & n[0]);
            check(auxPumpNegative, m & n[1]);
            check(mainPumpGain, mGain);
            check(propPumpGain, 0);
         end
      end
      $display("polarity and gain done");
      put(devWord(1'b1, 12'h003));
      for (n = 0; n < 4; n++)
      begin
         put(mainWord(2'h1, 5'h08, 4'h0, 2'(n), 1'b0, 4'hf));
         put(gainWord(8'h00, 4'h0, 4'h0, 2'(n), 1'b0));
         repeat (3) periodOf(1'b0, e);
         check(e, 3 << n);
         repeat (3) periodOf(1'b1, e);
         check(e, 3 << n);
      end
      $display("postscalers done");
      put(devWord(1'b1, 12'h002));
      foreach (gl[i])
      begin
         propG = 4'(rnd());
         integG = 4'(rnd());
         nd = 10'(rnd());
         put(gainWord(8'h40, propG, integG, 2'h0, 1'b0));
         put(mainWord(2'h1, 5'h08, 4'h0, 2'h1, 1'b0, 4'(gl[i])));
         fork
            i_host.send(divWord(nd, 12'h0a5), 1);
            spanOf(n, pg, ig);
         join
         // ratio is reference count 2 times postscale 2
         e = (gl[i] == 15) ? 1 : (gl[i] + 1) * 2 * 2 * 16;
         check(n, e);
         check(pg, propG);
         check(ig, integG);
         check(mainDivide, nd);
         check(auxDivide, 12'h0a5);
      end
      put(devWord(1'b0, 12'h002));
      fork
         i_host.send(mainWord(2'h1, 5'h00, 4'h0, 2'h1, 1'b0, 4'h0), 12);
         spanOf(n, pg, ig);
      join
      check(n, 12);
      check(pg, propG);
      $display("speed-up done");
      // keep the mid-run reset on the same launch point as every other input
      @(posedge clk) #1;
      doReset();
      check(fracAccum, 0);
      put(devWord(1'b1, 12'h001));
      nd = 10'(rnd());
      put(divWord(nd, 12'h001));
      numer = 4'h3 + 4'(rnd() % 4);
      i_host.send(mainWord(2'h1, 5'h07, numer, 2'h0, 1'b0, 4'hf), 1);
      n = 0;
      while (fracAccum === 5'h00 && n < 10)
      begin
         @(negedge clk);
         n++;
      end
      acc = numer;
      crr = 0;
      for (n = 0; n < 30; n++)
      begin
         check(fracAccum, acc);
         check(mainRatio, nd + crr);
         check(mainPdTick, 1);
         @(negedge clk);
         crr = (acc + numer >= 7);
         acc = (acc + numer) % 7;
      end
      $display("accumulator done");
      stop_test();
   end

   // the tests need roughly 6000 cycles; this allows about eight times that
   initial
   begin
      #1000000;
      fails++;
      $display("watchdog expired");
      stop_test();
   end

endmodule
